// ==== logic/wsw_pkg.sv ====
// Shared constants and types for the wireless module sleep and wake controller.
package wsw_pkg;

  // Core clock rate and the millisecond tick derived from it.
  localparam int CLK_HZ        = 100_000_000;
  localparam int MS_PER_S      = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

  // Timer width; every programmed time is counted in milliseconds.
  localparam int TMR_W = 16;

  // Fixed check window after a cyclic wake, in milliseconds.
  localparam logic [15:0] CHECK_WINDOW_MS = 16'h001E;
  // Expected time to transmit after a deep pin wake, in milliseconds.
  localparam logic [15:0] REJOIN_READY_MS = 16'h00A0;

  // Number of configurable I/O lines and width of a function code.
  localparam int NUM_LINES = 13;
  localparam int FUNC_W    = 4;

  // Line indices of the pins whose function steers sleep behaviour.
  localparam logic [3:0] PIN12_LINE = 4'h7;
  localparam logic [3:0] PIN9_LINE  = 4'h8;
  localparam logic [3:0] PIN13_LINE = 4'h9;

  // Function codes of a pin selector; anything above the last is unsupported.
  localparam logic [3:0] FN_DISABLED = 4'h0;
  localparam logic [3:0] FN_PERIPH   = 4'h1;
  localparam logic [3:0] FN_ANALOG   = 4'h2;
  localparam logic [3:0] FN_MONITOR  = 4'h3;
  localparam logic [3:0] FN_OUT_LOW  = 4'h4;
  localparam logic [3:0] FN_OUT_HIGH = 4'h5;
  localparam logic [3:0] FN_EN485_LO = 4'h6;
  localparam logic [3:0] FN_EN485_HI = 4'h7;

  // Codes each line accepts, one bit per code, line 0 first.
  localparam logic [7:0] ALLOW_MASK [0:12] = '{
    8'h3D, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3B, 8'h3B,
    8'hFB, 8'h3B, 8'h3B, 8'h3D, 8'h3D, 8'h3B};

  // Function of each line after reset: sleep request, flow control and indicator on.
  localparam logic [3:0] FUNC_RST [0:12] = '{
    4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
    4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};

  // Reset values of the pull resistor enable mask and direction select.
  localparam logic [12:0] PULL_EN_RST  = 13'h1FFF;
  localparam logic [12:0] PULL_DIR_RST = 13'h1FFF;

  // Sleep sequencer states.
  typedef enum logic [2:0] {
    WSW_AWAKE,
    WSW_ASLEEP,
    WSW_CHECK,
    WSW_HOLD,
    WSW_JOIN
  } wsw_state_t;

endpackage : wsw_pkg

// ==== logic/wsw_pin_cfg.sv ====
// Staged pin function selectors with apply, range check and pull resistor settings.
module wsw_pin_cfg #(
  parameter int LINES = wsw_pkg::NUM_LINES
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [3:0]            cfg_line,
  input  wire logic [3:0]            cfg_func,
  input  wire logic                  cfg_write,
  input  wire logic                  cfg_apply,
  input  wire logic [LINES-1:0]      pull_mask_in,
  input  wire logic                  pull_mask_write,
  input  wire logic [LINES-1:0]      pull_dir_in,
  input  wire logic                  pull_dir_write,
  output logic [LINES-1:0][3:0]      active_func,
  output logic                       cfg_reject,
  output logic [LINES-1:0]           pull_enable_mask,
  output logic [LINES-1:0]           pull_direction_select
);

  // Written values wait here until software applies them.
  logic [3:0] staged_r [0:LINES-1];

  // A code is accepted only for a real line, a supported value and a code that line allows.
  wire line_ok_w = cfg_line < 4'(LINES);
  wire code_ok_w = cfg_func <= wsw_pkg::FN_EN485_HI;
  wire allow_w   = line_ok_w && code_ok_w && wsw_pkg::ALLOW_MASK[cfg_line][cfg_func[2:0]];

  // A rejected write leaves the staged value alone and raises a one-cycle flag.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reject <= 1'h0;
    end else begin
      cfg_reject <= cfg_write && !allow_w;
    end
  end

  // Staging and apply; new functions reach the pins only on apply.
  always_ff @(posedge clk) begin
    for (int i = 0; i < LINES; i++) begin
      if (sys_rst) begin
        staged_r[i]    <= wsw_pkg::FUNC_RST[i];
        active_func[i] <= wsw_pkg::FUNC_RST[i];
      end else begin
        if (cfg_write && allow_w && cfg_line == 4'(i)) begin
          staged_r[i] <= cfg_func;
        end
        if (cfg_apply) begin
          active_func[i] <= staged_r[i];
        end
      end
    end
  end

  // The enable mask is written as a whole word so every line changes together.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pull_enable_mask      <= wsw_pkg::PULL_EN_RST;
      pull_direction_select <= wsw_pkg::PULL_DIR_RST;
    end else begin
      if (pull_mask_write) begin
        pull_enable_mask <= pull_mask_in;
      end
      if (pull_dir_write) begin
        pull_direction_select <= pull_dir_in;
      end
    end
  end

endmodule : wsw_pin_cfg

// ==== logic/wsw_sleep_ctrl.sv ====
// Sleep and wake sequencer with wake delay, sampling and pin function control.
// What this block does
// - Associated pin sleep: flag pending data at beacons.
// - Host wakes device; device then delivers pending data.
// - Attention output asserted whenever data is available.
// - UART data accepted awake, sent at beacon, or at once in deep sleep.
// - SPI wake by select, or by request release alone if the sleep pin is on.
// - Cyclic wake opens a 30 ms check window.
// - Activity holds awake full wake time, no restart.
// - Deep pin sleep powers radio off, rejoins.
// - Prior association: ready 160 ms after wake.
// - Deep cyclic uses sleep, wake, association wait.
// - Association wait expiry sleeps, retries next wake.
// - Wake duration over interval plus one samples.
// - Serial output and sampling wait host delay.
// - Indicators and outputs change at once on wake.
// - Deep sleep samples need delay and association.
// - Pin function codes decoded, above seven unsupported.
// - Pin functions take effect only on apply.
// - Pull enable mask and direction select provided.
// - Awake indicator low asleep, high awake.
// - Flow control: clear-to-send high asleep, low awake.
module wsw_sleep_ctrl #(
  parameter int CYCLES_PER_MS = wsw_pkg::CYCLES_PER_MS
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        SLEEP_REQUEST_LINE,
  input  wire logic        SERIAL_SELECT_N,
  input  wire logic        SPI_MODE,
  input  wire logic        DEEP_SLEEP,
  input  wire logic        CYCLIC_SLEEP,
  input  wire logic [15:0] SLEEP_PERIOD,
  input  wire logic [15:0] WAKE_DURATION,
  input  wire logic [15:0] ASSOCIATION_WAIT,
  input  wire logic [15:0] SAMPLE_INTERVAL,
  input  wire logic [15:0] HOST_WAKE_DELAY,
  input  wire logic        BEACON_TICK,
  input  wire logic        RX_PENDING,
  input  wire logic        HOST_TRAFFIC,
  input  wire logic        ASSOCIATED,
  input  wire logic [3:0]  CFG_LINE,
  input  wire logic [3:0]  CFG_FUNC,
  input  wire logic        CFG_WRITE,
  input  wire logic        CFG_APPLY,
  input  wire logic [12:0] PULL_MASK_IN,
  input  wire logic        PULL_MASK_WRITE,
  input  wire logic [12:0] PULL_DIR_IN,
  input  wire logic        PULL_DIR_WRITE,
  output logic             AWAKE_INDICATOR_PIN,
  output logic             CLEAR_TO_SEND_N,
  output logic             ATTENTION_OUT_N,
  output logic             RADIO_POWER,
  output logic             ASSOC_START,
  output logic             TX_READY,
  output logic             SERIAL_OUT_EN,
  output logic             DELIVER_EN,
  output logic             DATA_ACCEPT,
  output logic             TX_RELEASE,
  output logic             SAMPLE_STROBE,
  output logic [3:0]       PIN9_FUNCTION,
  output logic [3:0]       PIN12_FUNCTION,
  output logic [12:0]      PULL_ENABLE_MASK,
  output logic [12:0]      PULL_DIRECTION_SELECT,
  output logic             CFG_REJECT
);

  localparam int DIV_W = $clog2(CYCLES_PER_MS);

  // True once a millisecond count has reached its programmed limit.
  function automatic logic reached(input logic [15:0] cnt, input logic [15:0] lim);
    return cnt >= lim;
  endfunction : reached

  // Saturating millisecond increment so a long stay never wraps to zero.
  function automatic logic [15:0] bump(input logic [15:0] cnt);
    return (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
  endfunction : bump

  logic [12:0][3:0]    func_w;      // Applied function of every line.
  logic [2:0]          req_sync_r;  // Sleep request synchroniser stages.
  logic [2:0]          sel_sync_r;  // Select synchroniser stages.
  logic                req_r;       // Filtered sleep request level.
  logic                sel_n_r;     // Filtered select level, low active.
  logic [DIV_W-1:0]    div_r;       // Millisecond divider.
  logic                tick_r;      // One-cycle millisecond enable.
  wsw_pkg::wsw_state_t state_r;     // Current sequencer state.
  wsw_pkg::wsw_state_t state_nxt;   // Next sequencer state.
  logic [15:0]         ms_cnt_r;    // Time spent in the current state.
  logic [15:0]         wk_cnt_r;    // Wake time, from check start or association.
  logic [15:0]         wh_cnt_r;    // Time since the last wake.
  logic [15:0]         rdy_cnt_r;   // Time since a deep wake.
  logic [15:0]         smp_tmr_r;   // Time since the last sample.
  logic [16:0]         smp_cnt_r;   // Samples taken in this wake.
  logic                pend_r;      // Data flagged at a beacon while asleep.
  logic                txq_r;       // Host data queued for the next beacon.
  logic                was_assoc_r; // Association held when sleep began.

  // Line functions come from the staged configuration block.
  wsw_pin_cfg #(
    .LINES (wsw_pkg::NUM_LINES)
  ) u_pin_cfg (
    .clk                   (CLK),
    .sys_rst               (SYS_RST),
    .cfg_line              (CFG_LINE),
    .cfg_func              (CFG_FUNC),
    .cfg_write             (CFG_WRITE),
    .cfg_apply             (CFG_APPLY),
    .pull_mask_in          (PULL_MASK_IN),
    .pull_mask_write       (PULL_MASK_WRITE),
    .pull_dir_in           (PULL_DIR_IN),
    .pull_dir_write        (PULL_DIR_WRITE),
    .active_func           (func_w),
    .cfg_reject            (CFG_REJECT),
    .pull_enable_mask      (PULL_ENABLE_MASK),
    .pull_direction_select (PULL_DIRECTION_SELECT)
  );

  // Peripheral code on a pin turns on its sleep-related role.
  wire sleep_pin_en_w = func_w[wsw_pkg::PIN9_LINE] == wsw_pkg::FN_PERIPH;
  wire flow_en_w      = func_w[wsw_pkg::PIN12_LINE] == wsw_pkg::FN_PERIPH;
  wire ind_en_w       = func_w[wsw_pkg::PIN13_LINE] == wsw_pkg::FN_PERIPH;
  wire use_sel_w      = SPI_MODE && !sleep_pin_en_w;

  // Request high sleeps; select negated sleeps when select owns sleep.
  wire host_sleep_w = use_sel_w ? sel_n_r : (sleep_pin_en_w && req_r);
  wire host_wake_w  = !host_sleep_w;

  // Sequencer timing decisions.
  wire sp_done_w    = tick_r && reached(ms_cnt_r, SLEEP_PERIOD);
  wire check_done_w = tick_r && reached(ms_cnt_r, wsw_pkg::CHECK_WINDOW_MS);
  wire st_done_w    = reached(wk_cnt_r, WAKE_DURATION);
  wire sa_done_w    = tick_r && reached(ms_cnt_r, ASSOCIATION_WAIT);
  wire activity_w   = HOST_TRAFFIC || RX_PENDING;
  // First state of a timed wake; it must carry the enum type, since a plain net is one bit.
  wsw_pkg::wsw_state_t wake_state_w;
  assign wake_state_w = DEEP_SLEEP ? wsw_pkg::WSW_JOIN : wsw_pkg::WSW_CHECK;

  // Pins from outside pass three flops; a change counts when stages two and three agree.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      req_sync_r <= 3'h0;
      sel_sync_r <= 3'h7;
      req_r      <= 1'h0;
      sel_n_r    <= 1'h1;
    end else begin
      req_sync_r <= {req_sync_r[1:0], SLEEP_REQUEST_LINE};
      sel_sync_r <= {sel_sync_r[1:0], SERIAL_SELECT_N};
      if (req_sync_r[1] == req_sync_r[2]) begin
        req_r <= req_sync_r[2];
      end
      if (sel_sync_r[1] == sel_sync_r[2]) begin
        sel_n_r <= sel_sync_r[2];
      end
    end
  end

  // Millisecond enable; every programmed time is counted in these ticks.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      div_r  <= '0;
      tick_r <= 1'h0;
    end else begin
      tick_r <= div_r == DIV_W'(CYCLES_PER_MS - 1);
      div_r  <= (div_r == DIV_W'(CYCLES_PER_MS - 1)) ? '0 : div_r + DIV_W'(1);
    end
  end

  // Next state; pin modes follow the host, cyclic modes follow the timers.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      wsw_pkg::WSW_AWAKE: begin
        if (CYCLIC_SLEEP) begin
          state_nxt = wake_state_w;
        end else if (host_sleep_w) begin
          state_nxt = wsw_pkg::WSW_ASLEEP;
        end
      end
      wsw_pkg::WSW_ASLEEP: begin
        if (!CYCLIC_SLEEP && host_wake_w) begin
          state_nxt = wsw_pkg::WSW_AWAKE;
        end else if (CYCLIC_SLEEP && sp_done_w) begin
          state_nxt = wake_state_w;
        end
      end
      wsw_pkg::WSW_CHECK: begin
        if (!CYCLIC_SLEEP) begin
          state_nxt = wsw_pkg::WSW_AWAKE;
        end else if (activity_w) begin
          state_nxt = wsw_pkg::WSW_HOLD;
        end else if (check_done_w) begin
          state_nxt = wsw_pkg::WSW_ASLEEP;
        end
      end
      wsw_pkg::WSW_HOLD: begin
        if (!CYCLIC_SLEEP) begin
          state_nxt = wsw_pkg::WSW_AWAKE;
        end else if (st_done_w) begin
          state_nxt = wsw_pkg::WSW_ASLEEP;
        end
      end
      wsw_pkg::WSW_JOIN: begin
        if (!CYCLIC_SLEEP) begin
          state_nxt = wsw_pkg::WSW_AWAKE;
        end else if (ASSOCIATED) begin
          state_nxt = wsw_pkg::WSW_HOLD;
        end else if (sa_done_w) begin
          state_nxt = wsw_pkg::WSW_ASLEEP;
        end
      end
    endcase
  end

  // Awake and wake-edge terms look at the next state so outputs move on the wake edge.
  wire awake_w    = state_nxt != wsw_pkg::WSW_ASLEEP;
  wire woke_w     = awake_w && state_r == wsw_pkg::WSW_ASLEEP;
  wire fell_w     = !awake_w && state_r != wsw_pkg::WSW_ASLEEP;
  wire wh_done_w  = !woke_w && reached(wh_cnt_r, HOST_WAKE_DELAY);
  wire data_av_w  = pend_r || (awake_w && RX_PENDING);
  wire accept_w   = awake_w && (!SPI_MODE || !sel_n_r);
  wire smp_ok_w   = awake_w && wh_done_w && (!DEEP_SLEEP || ASSOCIATED);
  wire [16:0] smp_lim_w = {1'h0, WAKE_DURATION / SAMPLE_INTERVAL} + 17'h0_0001;
  wire smp_due_w  = smp_cnt_r == 17'h0_0000 || reached(smp_tmr_r, SAMPLE_INTERVAL);
  wire smp_go_w   = smp_ok_w && SAMPLE_INTERVAL != 16'h0000 && smp_cnt_r < smp_lim_w && smp_due_w;
  // A window entered from a steady wake also starts the wake timer, or a stale count cuts it short.
  wire check_start_w = state_nxt == wsw_pkg::WSW_CHECK && state_r != wsw_pkg::WSW_CHECK;
  wire join_done_w   = state_r == wsw_pkg::WSW_JOIN && state_nxt == wsw_pkg::WSW_HOLD;

  // State register and state-relative timers.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r  <= wsw_pkg::WSW_AWAKE;
      ms_cnt_r <= 16'h0000;
    end else begin
      state_r  <= state_nxt;
      if (state_nxt != state_r) begin
        ms_cnt_r <= 16'h0000;
      end else if (tick_r) begin
        ms_cnt_r <= bump(ms_cnt_r);
      end
    end
  end

  // Wake timer starts with the check window or with association and is never restarted.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wk_cnt_r <= 16'h0000;
    end else if (woke_w || check_start_w || join_done_w) begin
      wk_cnt_r <= 16'h0000;
    end else if (tick_r) begin
      wk_cnt_r <= bump(wk_cnt_r);
    end
  end

  // Timers measured from the wake edge: host delay and deep rejoin readiness.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wh_cnt_r  <= 16'h0000;
      rdy_cnt_r <= 16'h0000;
    end else if (woke_w) begin
      wh_cnt_r  <= 16'h0000;
      rdy_cnt_r <= 16'h0000;
    end else if (tick_r) begin
      wh_cnt_r  <= bump(wh_cnt_r);
      rdy_cnt_r <= bump(rdy_cnt_r);
    end
  end

  // Sample pacing: one at once, then one per interval, up to the wake quota.
  always_ff @(posedge CLK) begin
    if (SYS_RST || woke_w) begin
      smp_cnt_r <= 17'h0_0000;
      smp_tmr_r <= 16'h0000;
    end else if (smp_go_w) begin
      smp_cnt_r <= smp_cnt_r + 17'h0_0001;
      smp_tmr_r <= 16'h0000;
    end else if (tick_r) begin
      smp_tmr_r <= bump(smp_tmr_r);
    end
  end

  // Pending and queued flags; a new event wins over a clear in the same cycle.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pend_r      <= 1'h0;
      txq_r       <= 1'h0;
      was_assoc_r <= 1'h0;
    end else begin
      if (!DEEP_SLEEP && state_r == wsw_pkg::WSW_ASLEEP && BEACON_TICK && RX_PENDING) begin
        pend_r <= 1'h1;
      end else if (DELIVER_EN) begin
        pend_r <= 1'h0;
      end
      if (accept_w && HOST_TRAFFIC) begin
        txq_r <= 1'h1;
      end else if (TX_RELEASE) begin
        txq_r <= 1'h0;
      end
      if (fell_w) begin
        was_assoc_r <= ASSOCIATED;
      end
    end
  end

  // Indicator outputs follow the next state so they change on the wake edge itself.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      AWAKE_INDICATOR_PIN <= 1'h0;
      CLEAR_TO_SEND_N     <= 1'h1;
      ATTENTION_OUT_N     <= 1'h1;
      RADIO_POWER         <= 1'h1;
      ASSOC_START         <= 1'h0;
    end else begin
      AWAKE_INDICATOR_PIN <= ind_en_w && awake_w;
      CLEAR_TO_SEND_N     <= !(flow_en_w && awake_w);
      ATTENTION_OUT_N     <= !data_av_w;
      RADIO_POWER         <= !(DEEP_SLEEP && !awake_w);
      ASSOC_START         <= DEEP_SLEEP && woke_w;
    end
  end

  // Data path gates: serial output waits for the host delay, transmit waits for a beacon except in deep sleep.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SERIAL_OUT_EN <= 1'h0;
      DELIVER_EN    <= 1'h0;
      DATA_ACCEPT   <= 1'h0;
      TX_RELEASE    <= 1'h0;
      TX_READY      <= 1'h0;
      SAMPLE_STROBE <= 1'h0;
    end else begin
      SERIAL_OUT_EN <= awake_w && wh_done_w;
      DELIVER_EN    <= awake_w && wh_done_w && data_av_w && (!SPI_MODE || !sel_n_r);
      DATA_ACCEPT   <= accept_w;
      TX_RELEASE    <= txq_r && !TX_RELEASE && (DEEP_SLEEP || BEACON_TICK);
      TX_READY      <= awake_w && (!DEEP_SLEEP || ASSOCIATED ||
                       (was_assoc_r && reached(rdy_cnt_r, wsw_pkg::REJOIN_READY_MS)));
      SAMPLE_STROBE <= smp_go_w;
    end
  end

  // Pin function views for pins 9 and 12, which carry sleep roles.
  assign PIN9_FUNCTION  = func_w[wsw_pkg::PIN9_LINE];
  assign PIN12_FUNCTION = func_w[wsw_pkg::PIN12_LINE];

  // Checks kept beside the logic they guard.
  a_cts_high_asleep: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_r == wsw_pkg::WSW_ASLEEP && $past(flow_en_w)) |-> CLEAR_TO_SEND_N)
    else $error("clear-to-send low while asleep");
  a_awake_ind_high: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!$past(SYS_RST) && state_r != wsw_pkg::WSW_ASLEEP && $past(ind_en_w))
    |-> AWAKE_INDICATOR_PIN)
    else $error("awake indicator low while awake");
  a_radio_off_deep: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_r == wsw_pkg::WSW_ASLEEP && $past(DEEP_SLEEP)) |-> !RADIO_POWER)
    else $error("radio powered in deep sleep");
  a_check_window_len: assert property (@(posedge CLK) disable iff (SYS_RST)
    state_r == wsw_pkg::WSW_CHECK |-> ms_cnt_r <= wsw_pkg::CHECK_WINDOW_MS)
    else $error("check window overran");
  a_hold_no_restart: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_r == wsw_pkg::WSW_HOLD && $past(state_r) == wsw_pkg::WSW_HOLD)
    |-> wk_cnt_r >= $past(wk_cnt_r))
    else $error("wake timer restarted");
  a_join_gives_up: assert property (@(posedge CLK) disable iff (SYS_RST)
    (state_r == wsw_pkg::WSW_JOIN && CYCLIC_SLEEP && !ASSOCIATED && sa_done_w)
    |=> state_r == wsw_pkg::WSW_ASLEEP)
    else $error("association wait did not end in sleep");
  a_serial_waits: assert property (@(posedge CLK) disable iff (SYS_RST)
    (woke_w && HOST_WAKE_DELAY != 16'h0000) |=> !SERIAL_OUT_EN ##1 !SERIAL_OUT_EN)
    else $error("serial output before host delay");
  a_deep_sample: assert property (@(posedge CLK) disable iff (SYS_RST)
    (SAMPLE_STROBE && $past(DEEP_SLEEP)) |-> $past(ASSOCIATED))
    else $error("deep sample before association");
  a_sample_quota: assert property (@(posedge CLK) disable iff (SYS_RST)
    SAMPLE_STROBE |-> smp_cnt_r <= $past(smp_lim_w))
    else $error("too many samples in one wake");
  a_tx_at_beacon: assert property (@(posedge CLK) disable iff (SYS_RST)
    (TX_RELEASE && !$past(DEEP_SLEEP)) |-> $past(BEACON_TICK))
    else $error("queued data released off beacon");

endmodule : wsw_sleep_ctrl

// ==== test/wsw_host_model.sv ====
// Host microcontroller model that drives the sleep request and serial select lines.
module wsw_host_model (
  input  wire logic clk,
  input  wire logic want_sleep,
  input  wire logic want_sel,
  input  wire logic auto_wake,
  input  wire logic attn_n,
  output logic      sleep_line,
  output logic      select_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines change just after the edge; high asks for sleep, and attention releases it when auto_wake is set.
  always @(posedge clk) begin
    #1;
    sleep_line = want_sleep && !(auto_wake && !attn_n);
    select_n = !want_sel;
  end
endmodule : wsw_host_model

// ==== test/tb.sv ====
// Self-checking bench for the sleep and wake sequencer and pin configuration.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, want_sleep = 0, want_sel = 0, auto_wake = 0, deep = 0;
  logic beacon = 0, rxp = 0, traffic = 0, cwr = 0, capp = 0, pmw = 0, pdw = 0;
  logic rej_seen = 0, ast_seen = 0;
  logic spi = 0, cyc = 0, assoc = 1, rel_seen = 0;
  logic [15:0] sintv = 16'h0000;
  logic [3:0]  cline = 4'h8, cfunc = 4'h0, exp9 = 4'h1;
  logic [12:0] pmask = 13'h0000, pdir = 13'h0000;
  wire sleep_line, sel_n, ind, cts_n, attn_n, rpow, astart, sout, dlv, rej;
  wire txr, dacc, rel, sstb;
  wire [3:0]   p9, p12;
  wire [12:0]  pen, pdr;
  int fail_count = 0, checks = 0, seed = 87061, c, smp_seen = 0;
  // Fast millisecond tick keeps the run short.
  wsw_sleep_ctrl #(.CYCLES_PER_MS(10)) wsw_sleep_ctrl_i (.CLK(clk), .SYS_RST(rst),
    .SLEEP_REQUEST_LINE(sleep_line), .SERIAL_SELECT_N(sel_n), .SPI_MODE(spi),
    .DEEP_SLEEP(deep), .CYCLIC_SLEEP(cyc), .SLEEP_PERIOD(16'h0002),
    .WAKE_DURATION(16'h0005), .ASSOCIATION_WAIT(16'h0005), .SAMPLE_INTERVAL(sintv),
    .HOST_WAKE_DELAY(16'h0003), .BEACON_TICK(beacon), .RX_PENDING(rxp),
    .HOST_TRAFFIC(traffic), .ASSOCIATED(assoc), .CFG_LINE(cline), .CFG_FUNC(cfunc),
    .CFG_WRITE(cwr), .CFG_APPLY(capp), .PULL_MASK_IN(pmask), .PULL_MASK_WRITE(pmw),
    .PULL_DIR_IN(pdir), .PULL_DIR_WRITE(pdw), .AWAKE_INDICATOR_PIN(ind),
    .CLEAR_TO_SEND_N(cts_n), .ATTENTION_OUT_N(attn_n), .RADIO_POWER(rpow),
    .ASSOC_START(astart), .TX_READY(txr), .SERIAL_OUT_EN(sout), .DELIVER_EN(dlv),
    .DATA_ACCEPT(dacc), .TX_RELEASE(rel), .SAMPLE_STROBE(sstb), .PIN9_FUNCTION(p9),
    .PIN12_FUNCTION(p12), .PULL_ENABLE_MASK(pen), .PULL_DIRECTION_SELECT(pdr),
    .CFG_REJECT(rej));
  wsw_host_model wsw_host_model_i (.clk(clk), .want_sleep(want_sleep), .want_sel(want_sel),
    .auto_wake(auto_wake), .attn_n(attn_n), .sleep_line(sleep_line), .select_n(sel_n));
  // Free-running core clock.
  always #5 clk = ~clk;
  // Pulses are caught here so their exact cycle does not matter.
  always @(posedge clk) begin
    if (rej === 1'b1) rej_seen = 1;
    if (astart === 1'b1) ast_seen = 1;
    if (rel === 1'b1) rel_seen = 1;
    if (sstb === 1'b1) smp_seen++;
  end
  // A code is refused unless the line lists it among its accepted codes.
  function automatic logic exp_reject(logic [3:0] ln, logic [3:0] fn);
    return !(ln <= 4'hC && fn <= 4'h7 && wsw_pkg::ALLOW_MASK[ln][fn[2:0]]);
  endfunction : exp_reject
  // Samples per wake are the wake time over the interval, plus one.
  function automatic int exp_samples(int st, int ir);
    return st / ir + 1;
  endfunction : exp_samples
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(string what, logic [12:0] exp, logic [12:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One pin sleep and wake; the radio is expected off only in deep sleep.
  task automatic sleep_wake(logic exp_pow);
    want_sleep = 1;
    tick(10);
    chk("indicator", 1'b0, ind);
    chk("cts_n", 1'b1, cts_n);
    chk("radio", exp_pow, rpow);
    ast_seen = 0;
    want_sleep = 0;
    tick(8);
    chk("indicator", 1'b1, ind);
    chk("cts_n", 1'b0, cts_n);
    chk("serial_out", 1'b0, sout);
    chk("radio", 1'b1, rpow);
    chk("assoc_start", !exp_pow, ast_seen);
    tick(40);
    chk("serial_out", 1'b1, sout);
    $display("sleep test done");
  endtask : sleep_wake
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // The watchdog ends a hung run as a failure.
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    tick(10);
    rst = 0;
    tick(6);
    chk("pin9_func", 4'h1, p9);
    chk("pin12_func", 4'h1, p12);
    chk("pull_en", wsw_pkg::PULL_EN_RST, pen);
    sleep_wake(1'b1);
    // Code 0 first and code 1 last, so the sleep request pin ends up enabled again.
    for (c = 16; c > 0; c--) begin
      cfunc = c[3:0];
      rej_seen = 0;
      cwr = 1;
      tick(1);
      cwr = 0;
      tick(2);
      chk("reject", exp_reject(cline, cfunc), rej_seen);
      chk("pin9_unapplied", exp9, p9);
      capp = 1;
      tick(1);
      capp = 0;
      tick(2);
      if (!exp_reject(cline, cfunc)) exp9 = cfunc;
      chk("pin9_applied", exp9, p9);
    end
    $display("config test done");
    pmask = 13'($random(seed));
    pdir = 13'($random(seed));
    pmw = 1;
    pdw = 1;
    tick(1);
    pmw = 0;
    pdw = 0;
    tick(2);
    chk("pull_en", pmask, pen);
    chk("pull_dir", pdir, pdr);
    $display("pull test done");
    spi = 1;
    tick(8);
    chk("accept_unselected", 1'b0, dacc);
    want_sel = 1;
    tick(8);
    chk("accept_selected", 1'b1, dacc);
    want_sel = 0;
    spi = 0;
    $display("select test done");
    auto_wake = 1;
    want_sleep = 1;
    tick(10);
    rxp = 1;
    beacon = 1;
    tick(1);
    beacon = 0;
    tick(3);
    chk("attention_n", 1'b0, attn_n);
    tick(50);
    chk("indicator", 1'b1, ind);
    chk("deliver", 1'b1, dlv);
    rxp = 0;
    want_sleep = 0;
    auto_wake = 0;
    $display("pending test done");
    tick(20);
    deep = 1;
    sleep_wake(1'b0);
    assoc = 0;
    smp_seen = 0;
    sintv = 16'h0002;
    tick(50);
    chk("samples_unassoc", 13'h0000, 13'(smp_seen));
    chk("tx_ready_rejoin", 1'b0, txr);
    assoc = 1;
    tick(150);
    chk("samples", 13'(exp_samples(5, 2)), 13'(smp_seen));
    chk("tx_ready", 1'b1, txr);
    $display("sample test done");
    sintv = 16'h0000;
    deep = 0;
    cyc = 1;
    rel_seen = 0;
    traffic = 1;
    tick(2);
    traffic = 0;
    tick(58);
    chk("cyclic_asleep", 1'b0, ind);
    tick(40);
    chk("cyclic_wake", 1'b1, ind);
    cyc = 0;
    tick(2);
    chk("tx_held", 1'b0, rel_seen);
    beacon = 1;
    tick(1);
    beacon = 0;
    tick(2);
    chk("tx_release", 1'b1, rel_seen);
    $display("cyclic test done");
    report_and_stop();
  end
endmodule : tb
